// ---- hpt_pkg.sv ----
// constants for the host port pin configuration and transmit path
package hpt_pkg;
  // core peripheral addresses
  localparam logic [23:0] ADDR_TX   = 24'hFFFFC7;
  localparam logic [23:0] ADDR_PCR  = 24'hFFFFC4;
  localparam logic [23:0] ADDR_CTRL = 24'hFFFFC0;
  localparam logic [23:0] ADDR_STAT = 24'hFFFFC3;
  localparam logic [23:0] ADDR_DDR  = 24'hFFFFC8;
  localparam logic [23:0] ADDR_DR   = 24'hFFFFC9;
  // port_pin_control fields
  localparam int PCR_GEN  = 0;
  localparam int PCR_A8EN = 1;
  localparam int PCR_A9EN = 2;
  localparam int PCR_CSEN = 3;
  localparam int PCR_REN  = 4;
  localparam int PCR_AEN  = 5;
  localparam int PCR_EN   = 6;
  localparam int PCR_ROD  = 8;
  localparam int PCR_DSP  = 9;
  localparam int PCR_MUX  = 11;
  localparam int PCR_DDS  = 12;
  localparam logic [15:0] PCR_RESET = 16'h0000;
  localparam logic [15:0] PCR_MASK  = 16'h1B7F;
  // dsp_side_control and dsp_side_status fields
  localparam int CTRL_TIE = 0;
  localparam int STAT_TDE = 1;
  // shared pin indices
  localparam int PIN_REQ = 0;
  localparam int PIN_ACK = 1;
  localparam int PIN_CS  = 2;
  localparam int PIN_A9  = 3;
  localparam int PIN_A8  = 4;
  localparam int PIN_SA  = 5;
  localparam int PIN_SB  = 6;
  localparam int NPIN    = 7;
  // cycles from a core write until affected status reads back
  localparam int STATUS_DELAY = 2;
  typedef enum logic [1:0] {
    HPT_TX_EMPTY = 2'h1,
    HPT_TX_HELD  = 2'h2
  } hpt_tx_state_t;
endpackage

// ---- hpt_sync3.sv ----
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module hpt_sync3 #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // pins and filtered levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  for (genvar k = 0; k < W; k++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        s1_r[k] <= 1'b0;
        s2_r[k] <= 1'b0;
        s3_r[k] <= 1'b0;
        q_o[k]  <= 1'b0;
      end else if (ce_i) begin
        s1_r[k] <= d_i[k];
        s2_r[k] <= s1_r[k];
        s3_r[k] <= s2_r[k];
        // a change counts once the last two stages agree
        if (s2_r[k] == s3_r[k]) begin
          q_o[k] <= s3_r[k];
        end
      end
    end
  end
endmodule

// ---- hpt_fifo.sv ----
// word fifo with registered output stage
`timescale 1ns/1ps
module hpt_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          load;
  logic          take;

  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  assign take = !out_valid_o || out_ready_i;
  assign load = take && (cnt_r != '0);

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_r[wptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else if (ce_i) begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (load) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (ce_i && take) begin
      out_valid_o <= (cnt_r != '0);
      if (load) begin
        out_data_o <= mem_r[rptr_r];
      end
    end
  end
endmodule

// ---- hpt_top.sv ----
// host port pin configuration, core transmit register and host receive path
`timescale 1ns/1ps
module hpt_top #(
  parameter int FIFO_DEPTH = 32,
  parameter int GPIO_W     = hpt_pkg::NPIN
) (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // core peripheral bus
  input  wire logic [23:0]         core_addr_i,
  input  wire logic                core_wr_i,
  input  wire logic                core_rd_i,
  input  wire logic [23:0]         core_wdata_i,
  output logic      [23:0]         core_rdata_o,
  output logic                     core_rvalid_o,
  output logic                     tx_irq_o,
  // host side logic
  input  wire logic                double_request_mode_i,
  input  wire logic                host_tx_space_i,
  output logic      [23:0]         host_word_o,
  output logic                     host_word_valid_o,
  input  wire logic                host_word_ready_i,
  output logic                     host_rx_full_o,
  // decoded host bus levels
  output logic                     host_read_active_o,
  output logic                     host_write_active_o,
  output logic                     host_cs_active_o,
  output logic                     host_ack_active_o,
  output logic      [2:0]          host_addr_hi_o,
  // shared pins
  input  wire logic [GPIO_W-1:0]   pin_i,
  output logic      [GPIO_W-1:0]   pin_o,
  output logic      [GPIO_W-1:0]   pin_oe_o
);
  logic [15:0]       pcr_r;
  logic              tie_r;
  logic [GPIO_W-1:0] ddr_r;
  logic [GPIO_W-1:0] dr_r;
  logic [23:0]       tx_word_r;
  logic              tx_empty_r;
  logic              pv_r;
  logic [23:0]       pd_r;
  logic [23:0]       rx_word_r;
  logic              rx_full_r;
  logic [GPIO_W-1:0] ps;
  logic [GPIO_W-1:0] host_fn;
  logic [GPIO_W-1:0] host_out;
  logic [GPIO_W-1:0] host_oe;
  logic              en;
  logic              ren;
  logic              mux;
  logic              drq;
  logic              xfer;
  logic              fifo_ready;
  logic              sa_act;
  logic              sb_act;
  logic              req_assert;
  logic              rrq_assert;
  logic [23:0]       rd_nxt;
  logic [23:0]       gpio_rd;
  hpt_pkg::hpt_tx_state_t tx_state;

  assign en  = pcr_r[hpt_pkg::PCR_EN];
  assign ren = pcr_r[hpt_pkg::PCR_REN];
  assign mux = pcr_r[hpt_pkg::PCR_MUX];
  assign drq = double_request_mode_i;
  assign tx_state = tx_empty_r ? hpt_pkg::HPT_TX_EMPTY : hpt_pkg::HPT_TX_HELD;

  hpt_sync3 #(
    .W (GPIO_W)
  ) u_sync (
    .clk_i (clk_sys_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pin_i),
    .q_o   (ps)
  );

  // register writes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pcr_r <= hpt_pkg::PCR_RESET;
      tie_r <= 1'b0;
      ddr_r <= '0;
      dr_r  <= '0;
    end else if (ce_i && core_wr_i) begin
      case (core_addr_i)
        hpt_pkg::ADDR_PCR: begin
          pcr_r <= core_wdata_i[15:0] & hpt_pkg::PCR_MASK;
        end
        hpt_pkg::ADDR_CTRL: begin
          tie_r <= core_wdata_i[hpt_pkg::CTRL_TIE];
        end
        hpt_pkg::ADDR_DDR: begin
          ddr_r <= core_wdata_i[GPIO_W-1:0];
        end
        hpt_pkg::ADDR_DR: begin
          dr_r <= core_wdata_i[GPIO_W-1:0];
        end
        default: begin
          pcr_r <= pcr_r;
        end
      endcase
    end
  end

  // transmit writes pass one stage so status lags the write by two cycles
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pv_r <= 1'b0;
      pd_r <= '0;
    end else if (ce_i) begin
      pv_r <= core_wr_i && (core_addr_i == hpt_pkg::ADDR_TX);
      pd_r <= core_wdata_i;
    end
  end

  assign xfer = en && !tx_empty_r && !rx_full_r;

  // transmit register and empty flag; the transfer's set wins over a write
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_word_r  <= '0;
      tx_empty_r <= 1'b1;
    end else if (ce_i) begin
      if (pv_r) begin
        tx_word_r <= pd_r;
      end
      if (!en || xfer) begin
        tx_empty_r <= 1'b1;
      end else if (pv_r) begin
        tx_empty_r <= 1'b0;
      end
    end
  end

  // host receive word register, drained into the fifo
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rx_word_r <= '0;
      rx_full_r <= 1'b0;
    end else if (ce_i) begin
      if (xfer) begin
        rx_word_r <= tx_word_r;
        rx_full_r <= 1'b1;
      end else if (!en || fifo_ready) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  hpt_fifo #(
    .W     (24),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_sys_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (rx_full_r && en),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rx_word_r),
    .out_valid_o (host_word_valid_o),
    .out_ready_i (host_word_ready_i),
    .out_data_o  (host_word_o)
  );

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_irq_o       <= 1'b0;
      host_rx_full_o <= 1'b0;
    end else if (ce_i) begin
      tx_irq_o       <= tie_r && tx_empty_r;
      host_rx_full_o <= rx_full_r;
    end
  end

  // pin functions
  assign req_assert = drq ? host_tx_space_i : rx_full_r;
  assign rrq_assert = rx_full_r;
  always_comb begin
    host_fn  = '0;
    host_out = '1;
    host_oe  = '0;
    host_fn[hpt_pkg::PIN_REQ] = en && ren;
    host_fn[hpt_pkg::PIN_ACK] = en && ren && (drq || pcr_r[hpt_pkg::PCR_AEN]);
    host_fn[hpt_pkg::PIN_CS]  = en && pcr_r[hpt_pkg::PCR_CSEN];
    host_fn[hpt_pkg::PIN_A9]  = en && mux && pcr_r[hpt_pkg::PCR_A9EN];
    host_fn[hpt_pkg::PIN_A8]  = en && mux && pcr_r[hpt_pkg::PCR_A8EN];
    host_fn[hpt_pkg::PIN_SA]  = en;
    host_fn[hpt_pkg::PIN_SB]  = en;
    // requests are active low; open drain drives only the asserted level
    host_out[hpt_pkg::PIN_REQ] = !req_assert;
    host_oe[hpt_pkg::PIN_REQ]  = !pcr_r[hpt_pkg::PCR_ROD] || req_assert;
    host_out[hpt_pkg::PIN_ACK] = !rrq_assert;
    host_oe[hpt_pkg::PIN_ACK]  = drq && (!pcr_r[hpt_pkg::PCR_ROD] || rrq_assert);
  end

  for (genvar k = 0; k < GPIO_W; k++) begin : g_pin
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        pin_o[k]    <= 1'b0;
        pin_oe_o[k] <= 1'b0;
      end else if (ce_i) begin
        if (host_fn[k]) begin
          pin_o[k]    <= host_out[k];
          pin_oe_o[k] <= host_oe[k];
        end else begin
          pin_o[k]    <= dr_r[k];
          pin_oe_o[k] <= pcr_r[hpt_pkg::PCR_GEN] && ddr_r[k];
        end
      end
    end
    // disconnected gpio inputs read as zero
    assign gpio_rd[k] = ddr_r[k] ? dr_r[k]
                      : (pcr_r[hpt_pkg::PCR_GEN] && !host_fn[k] && ps[k]);
  end
  assign gpio_rd[23:GPIO_W] = '0;

  // strobe decoding
  assign sa_act = pcr_r[hpt_pkg::PCR_DSP] ? ps[hpt_pkg::PIN_SA] : !ps[hpt_pkg::PIN_SA];
  assign sb_act = pcr_r[hpt_pkg::PCR_DSP] ? ps[hpt_pkg::PIN_SB] : !ps[hpt_pkg::PIN_SB];
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      host_read_active_o  <= 1'b0;
      host_write_active_o <= 1'b0;
    end else if (ce_i) begin
      if (pcr_r[hpt_pkg::PCR_DDS]) begin
        host_write_active_o <= en && sa_act;
        host_read_active_o  <= en && sb_act;
      end else begin
        host_write_active_o <= en && sa_act && !ps[hpt_pkg::PIN_SB];
        host_read_active_o  <= en && sa_act && ps[hpt_pkg::PIN_SB];
      end
    end
  end

  // chip select, acknowledge and high address lines
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      host_cs_active_o  <= 1'b0;
      host_ack_active_o <= 1'b0;
      host_addr_hi_o    <= '0;
    end else if (ce_i) begin
      host_cs_active_o  <= host_fn[hpt_pkg::PIN_CS] && !mux && !ps[hpt_pkg::PIN_CS];
      host_ack_active_o <= host_fn[hpt_pkg::PIN_ACK] && !drq && !ps[hpt_pkg::PIN_ACK];
      host_addr_hi_o[2] <= host_fn[hpt_pkg::PIN_CS] && mux && ps[hpt_pkg::PIN_CS];
      host_addr_hi_o[1] <= host_fn[hpt_pkg::PIN_A9] && ps[hpt_pkg::PIN_A9];
      host_addr_hi_o[0] <= host_fn[hpt_pkg::PIN_A8] && ps[hpt_pkg::PIN_A8];
    end
  end

  // register reads; the transmit word is write-only and reads zero
  always_comb begin
    case (core_addr_i)
      hpt_pkg::ADDR_PCR:  rd_nxt = {8'h00, pcr_r};
      hpt_pkg::ADDR_CTRL: rd_nxt = 24'(tie_r);
      hpt_pkg::ADDR_STAT: rd_nxt = 24'(tx_state == hpt_pkg::HPT_TX_EMPTY) << hpt_pkg::STAT_TDE;
      hpt_pkg::ADDR_DDR:  rd_nxt = 24'(ddr_r);
      hpt_pkg::ADDR_DR:   rd_nxt = gpio_rd;
      default:            rd_nxt = 24'h000000;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_rdata_o  <= '0;
      core_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      core_rvalid_o <= core_rd_i;
      core_rdata_o  <= core_rd_i ? rd_nxt : 24'h000000;
    end
  end

  // checks
  chk_tx_write_delay: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    (core_wr_i && core_addr_i == hpt_pkg::ADDR_TX && en && tx_empty_r && !pv_r)
    ##1 (ce_i && en) |-> tx_empty_r ##1 !tx_empty_r)
    else $error("transmit write did not clear empty two cycles later");
  chk_write_clears: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    (pv_r && en && !xfer) |=> !tx_empty_r)
    else $error("transmit write left empty flag set");
  chk_xfer_gate: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    $rose(rx_full_r) |-> !$past(tx_empty_r) && $past(en))
    else $error("receive filled without a pending transmit word");
  chk_xfer_sets: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    xfer |=> tx_empty_r && rx_full_r && rx_word_r == $past(tx_word_r))
    else $error("copy did not set both flags with the word");
  chk_tx_irq_level: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    (tie_r && tx_empty_r) ##1 ce_i |-> tx_irq_o)
    else $error("transmit interrupt missing while empty");
  chk_disable_reset: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    !en |=> tx_empty_r && !rx_full_r)
    else $error("disabled port kept transfer state");
  chk_gpio_isolate: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    (!en && !pcr_r[hpt_pkg::PCR_GEN]) |=> pin_oe_o == '0)
    else $error("disconnected gpio pin is driven");
  chk_rrq_drive: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    (en && ren && drq && rx_full_r && !pcr_r[hpt_pkg::PCR_ROD])
    |=> pin_oe_o[hpt_pkg::PIN_ACK] && !pin_o[hpt_pkg::PIN_ACK])
    else $error("receive request not driven low");
  chk_open_drain: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    (en && ren && pcr_r[hpt_pkg::PCR_ROD] && !req_assert) |=> !pin_oe_o[hpt_pkg::PIN_REQ])
    else $error("open drain request drove high");
  chk_ack_input: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    (en && ren && !drq && pcr_r[hpt_pkg::PCR_AEN]) |=> !pin_oe_o[hpt_pkg::PIN_ACK])
    else $error("acknowledge input pin is driven");
  chk_addr_nomux: assert property (
    @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
    !mux |=> host_addr_hi_o == 3'h0)
    else $error("address lines active outside multiplexed mode");
  chk_reserved_bit: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (pcr_r & ~hpt_pkg::PCR_MASK) == 16'h0000)
    else $error("reserved control bit set");
  cov_copy: cover property (@(posedge clk_sys_i) disable iff (rst_i) xfer);
  cov_fifo_full: cover property (@(posedge clk_sys_i) disable iff (rst_i) !fifo_ready);
  cov_double_req: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    en && ren && drq && rx_full_r);
  cov_dual_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    host_write_active_o && pcr_r[hpt_pkg::PCR_DDS]);
endmodule

// ---- hpt_host_model.sv ----
// host processor model: drives the shared pins and drains the receive word stream
`timescale 1ns/1ps
module hpt_host_model (
  // clock and pacing
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  // receive word stream
  input  wire logic [23:0] word_i,
  input  wire logic        word_valid_i,
  output logic             word_ready_o,
  // shared pins
  input  wire logic [6:0]  pin_o_i,
  input  wire logic [6:0]  pin_oe_i,
  output logic      [6:0]  pin_lvl_o
);
  logic [31:0] seed;
  logic [6:0]  drv_en;
  logic [6:0]  drv_val;
  logic [23:0] rxq[$];
  initial begin
    seed = 32'h13CBE173;
    drv_en = 7'h00;
    drv_val = 7'h00;
    word_ready_o = 1'b0;
  end
  // device drive wins, then host drive, else the pull-up
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      pin_lvl_o[k] = pin_oe_i[k] ? pin_o_i[k] : (drv_en[k] ? drv_val[k] : 1'b1);
    end
  end
  // takes a word at the edge, then draws a new ready unless stalled
  always @(posedge clk_i) begin
    if (word_valid_i === 1'b1 && word_ready_o === 1'b1) begin
      rxq.push_back(word_i);
    end
    #2;
    word_ready_o <= !stall_i && (($random(seed) & 1) != 0);
  end
  task automatic drive(input logic [6:0] en, input logic [6:0] val);
    @(posedge clk_i) #2;
    drv_en = en;
    drv_val = val;
  endtask
  // single: strobe on pin 5, read level on pin 6; dual: write on 5, read on 6
  task automatic strobe(input logic dual, input logic pol, input logic rd, input logic act);
    @(posedge clk_i) #2;
    drv_en[6:5] = 2'b11;
    if (!dual) begin
      drv_val[5] = act ? pol : !pol;
      drv_val[6] = rd;
    end else begin
      drv_val[5] = (act && !rd) ? pol : !pol;
      drv_val[6] = (act && rd) ? pol : !pol;
    end
  endtask
endmodule

// ---- tb_host_port_pin_config_and_transmit.sv ----
// self-checking bench for pin configuration and the transmit word path
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module tb_host_port_pin_config_and_transmit;
  localparam int DEPTH = 32;
  localparam time D = 2;
  logic        clk_sys_i, rst_i, ce_i, core_wr, core_rd, dm, tx_space, stall;
  logic [23:0] core_addr, core_wdata, core_rdata, host_word, rd_val, w;
  logic        core_rvalid, tx_irq, host_valid, host_ready, rx_full;
  logic        rd_act, wr_act, cs_act, ack_act;
  logic [2:0]  addr_hi;
  logic [6:0]  pin_in, pin_out, pin_oe;
  int          n_fail, num_checks, seed, k, ok;
  logic [23:0] sent[$];

  hpt_top #(.FIFO_DEPTH(DEPTH)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .core_addr_i(core_addr), .core_wr_i(core_wr), .core_rd_i(core_rd),
    .core_wdata_i(core_wdata), .core_rdata_o(core_rdata), .core_rvalid_o(core_rvalid),
    .tx_irq_o(tx_irq), .double_request_mode_i(dm), .host_tx_space_i(tx_space),
    .host_word_o(host_word), .host_word_valid_o(host_valid), .host_word_ready_i(host_ready),
    .host_rx_full_o(rx_full), .host_read_active_o(rd_act), .host_write_active_o(wr_act),
    .host_cs_active_o(cs_act), .host_ack_active_o(ack_act), .host_addr_hi_o(addr_hi),
    .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe));
  hpt_host_model host (.clk_i(clk_sys_i), .stall_i(stall), .word_i(host_word),
    .word_valid_i(host_valid), .word_ready_o(host_ready), .pin_o_i(pin_out),
    .pin_oe_i(pin_oe), .pin_lvl_o(pin_in));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    n_fail++;
    report_and_stop();
  end
  task automatic wr(input logic [23:0] a, input logic [23:0] d);
    @(posedge clk_sys_i) #D;
    core_addr = a;
    core_wdata = d;
    core_wr = 1'b1;
    @(posedge clk_sys_i) #D core_wr = 1'b0;
  endtask
  task automatic rd(input logic [23:0] a);
    @(posedge clk_sys_i) #D;
    core_addr = a;
    core_rd = 1'b1;
    @(posedge clk_sys_i) #D core_rd = 1'b0;
    rd_val = core_rdata;
    `CHK("rvalid", 1'b1, core_rvalid)
  endtask
  task automatic settle;
    repeat (8) @(posedge clk_sys_i);
    #D;
  endtask
  task automatic cfg(input logic [23:0] v);
    wr(hpt_pkg::ADDR_PCR, v);
    settle();
  endtask
  task automatic poll_tde(output int got);
    got = 0;
    for (int i = 0; i < 20 && got == 0; i++) begin
      rd(hpt_pkg::ADDR_STAT);
      got = int'(rd_val[hpt_pkg::STAT_TDE] === 1'b1);
    end
  endtask
  task automatic drain;
    for (int i = 0; i < 4000 && host.rxq.size() < sent.size(); i++) @(posedge clk_sys_i);
    `CHK("drain_count", sent.size(), host.rxq.size())
    for (int i = 0; i < sent.size() && i < host.rxq.size(); i++) begin
      `CHK("host_word", sent[i], host.rxq[i])
    end
  endtask

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    {core_wr, core_rd, dm, tx_space, stall} = 5'h00;
    core_addr = 24'h000000;
    core_wdata = 24'h000000;
    n_fail = 0;
    num_checks = 0;
    seed = 32'h13CBE173;
    repeat (20) @(posedge clk_sys_i);
    #D rst_i = 1'b0;
    rd(hpt_pkg::ADDR_PCR);
    `CHK("pcr_reset", 24'h000000, rd_val)
    rd(hpt_pkg::ADDR_TX);
    `CHK("tx_read", 24'h000000, rd_val)
    rd(24'hFFFF00);
    `CHK("unmapped", 24'h000000, rd_val)
    `CHK("oe_reset", 7'h00, pin_oe)
    cfg(24'h00FF7F);
    rd(hpt_pkg::ADDR_PCR);
    `CHK("pcr_mask", 24'(hpt_pkg::PCR_MASK), rd_val)
    $display("test registers done");
    wr(hpt_pkg::ADDR_DDR, 24'h00007F);
    wr(hpt_pkg::ADDR_DR, 24'h000054);
    cfg(24'h000001);
    `CHK("gpio_oe", 7'h7F, pin_oe)
    `CHK("gpio_out", 7'h54, pin_out)
    rd(hpt_pkg::ADDR_DR);
    `CHK("dr_read", 24'h000054, rd_val)
    cfg(24'h000000);
    `CHK("gpio_off", 7'h00, pin_oe)
    cfg(24'h000041);
    `CHK("req_gpio", 4'hC, {pin_oe[1:0], pin_out[1:0]})
    host.drive(7'h1C, 7'h00);
    cfg(24'h000048);
    `CHK("cs_nogen", 1'b1, cs_act)
    `CHK("oe_nogen", 7'h00, pin_oe)
    cfg(24'h000040);
    `CHK("cs_off", 1'b0, cs_act)
    host.drive(7'h1C, 7'h14);
    cfg(24'h00084F);
    `CHK("addr_hi", 3'b101, addr_hi)
    `CHK("addr_in", 3'b000, pin_oe[4:2])
    cfg(24'h000849);
    `CHK("addr_gpio", 2'b11, pin_oe[4:3])
    $display("test pin functions done");
    dm = 1'b1;
    tx_space = 1'b1;
    cfg(24'h000051);
    `CHK("trq_on", 2'b10, {pin_oe[0], pin_out[0]})
    `CHK("rrq_off", 2'b11, {pin_oe[1], pin_out[1]})
    tx_space = 1'b0;
    settle();
    `CHK("trq_idle", 2'b11, {pin_oe[0], pin_out[0]})
    cfg(24'h000151);
    `CHK("od_idle", 1'b0, pin_oe[0])
    tx_space = 1'b1;
    settle();
    `CHK("od_on", 2'b10, {pin_oe[0], pin_out[0]})
    cfg(24'h000110);
    `CHK("req_noen", 1'b0, pin_oe[0])
    dm = 1'b0;
    cfg(24'h000051);
    `CHK("sreq_idle", 2'b11, {pin_oe[0], pin_out[0]})
    host.drive(7'h02, 7'h00);
    cfg(24'h000071);
    `CHK("ack_on", 2'b10, {ack_act, pin_oe[1]})
    cfg(24'h000061);
    `CHK("ack_noren", 1'b0, ack_act)
    dm = 1'b1;
    cfg(24'h000071);
    `CHK("ack_dbl", 1'b0, ack_act)
    dm = 1'b0;
    $display("test requests done");
    wr(hpt_pkg::ADDR_DDR, 24'h000000);
    for (k = 0; k < 8; k++) begin
      cfg({11'h000, k[1], 2'b00, k[0], 9'h040});
      host.strobe(k[1], k[0], k[2], 1'b1);
      settle();
      `CHK("strobe_rd", k[2], rd_act)
      `CHK("strobe_wr", !k[2], wr_act)
      host.strobe(k[1], k[0], k[2], 1'b0);
      settle();
      `CHK("strobe_idle", 2'b00, {rd_act, wr_act})
    end
    $display("test strobes done");
    cfg(24'h000040);
    wr(hpt_pkg::ADDR_CTRL, 24'h000001);
    settle();
    `CHK("irq_empty", 1'b1, tx_irq)
    w = 24'($random(seed));
    wr(hpt_pkg::ADDR_TX, w);
    rd(hpt_pkg::ADDR_STAT);
    `CHK("tde_clear", 1'b0, rd_val[hpt_pkg::STAT_TDE])
    sent.push_back(w);
    poll_tde(ok);
    `CHK("tde_set", 1, ok)
    drain();
    stall = 1'b1;
    ok = 1;
    for (k = 0; ok != 0 && k < DEPTH + 4; k++) begin
      w = 24'($random(seed));
      wr(hpt_pkg::ADDR_TX, w);
      sent.push_back(w);
      poll_tde(ok);
    end
    `CHK("fill_refused", 1'b1, ok == 0 && k >= DEPTH + 2)
    `CHK("rx_held", 1'b1, rx_full)
    `CHK("irq_held", 1'b0, tx_irq)
    // a disabling write while the clock enable is low must not land
    ce_i = 1'b0;
    cfg(24'h000000);
    `CHK("ce_hold", 2'b10, {rx_full, tx_irq})
    ce_i = 1'b1;
    cfg(24'h000050);
    `CHK("sreq_full", 2'b10, {pin_oe[0], pin_out[0]})
    dm = 1'b1;
    settle();
    `CHK("rrq_full", 2'b10, {pin_oe[1], pin_out[1]})
    dm = 1'b0;
    stall = 1'b0;
    poll_tde(ok);
    `CHK("tde_resume", 1, ok)
    drain();
    $display("test transmit done");
    report_and_stop();
  end
endmodule
